/* File: design/watchdog_consts.svh */
/*
 Constants of the board watchdog and reset control block: register
 indexes, bit positions, reset values and timing counts.
 Assumes a board clock of 20 MHz.
*/
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH

// Register indexes on the two-bit I/O address
`define REG_ENABLE_ID    2'h0
`define REG_WDT_CLEAR    2'h1
`define REG_SITE_RESET   2'h2

// Enable register fields
`define BIT_WATCHDOG_RESET_ENABLE       0
`define BIT_VARIANT      1
`define BIT_ACCESS_EN    2
`define BIT_CC_WATCHDOG_RESET_ENABLE    3

// Site reset register fields
`define BIT_PAR_SITE     0
`define BIT_SER_SITES    1
`define BIT_MINI_EXT     2

// Reset values
`define RESET_ENABLES    4'h0
`define RESET_SITES      3'h0

// Timing
`define CLK_HZ           20000000
`define CLK_PERIOD_NS    50
`define WDT_LATENCY_MS   1600
`define WDT_LATENCY_CYCLES (`WDT_LATENCY_MS * (`CLK_HZ / 1000))
`define BOARD_RESET_NS   800
`define BOARD_RESET_CYCLES ((`BOARD_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: design/watchdog_pkg.sv */
/*
 Types shared by the board watchdog and reset control block.
 Assumes the constants header is compiled alongside.
*/
package watchdog_pkg;

   typedef logic [24:0] wdt_count_t;
   typedef logic [3:0]  nibble_t;

   typedef enum logic [1:0] {
      BOARD_RUN       = 2'b01,
      BOARD_RESETTING = 2'b10
   } board_state_e;

   typedef struct packed {
      nibble_t      enables;
      logic [2:0]   sites;
      wdt_count_t   count;
      logic         expire;
      board_state_e bstate;
      logic [7:0]   rcount;
      logic         prev_cs_n;
      logic         prev_we_n;
      logic [1:0]   prev_addr;
      nibble_t      prev_data;
      nibble_t      rdata;
      logic         rdrive;
   } core_state_s;

endpackage

/* File: design/pin_sync_if.sv */
/*
 Carries a group of raw pin levels into the synchroniser and the
 settled levels back out. Assumes one clock domain on the user side.
*/
`timescale 1ns/1ps
`default_nettype none

interface pin_sync_if #(parameter int W = 10);
   logic [W-1:0] raw;
   logic [W-1:0] stable;
   modport sync (input raw, output stable);
   modport user (output raw, input stable);
endinterface

`default_nettype wire

/* File: design/pin_sync3.sv */
/*
 Three-stage synchroniser for a group of pin levels. A bit changes
 once the second and third stages agree. Assumes raw levels are
 asynchronous to clk and reset is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
   parameter int           W    = 10,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Pin group
   pin_sync_if.sync  pins
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] stable;
   } sync_state_s;

   sync_state_s s;
   sync_state_s next_s;

   generate
      if (W < 1) begin : g_chk
         $error("pin_sync3 needs W of at least 1");
      end
   endgenerate

   always_comb begin
      next_s        = s;
      next_s.s1     = pins.raw;
      next_s.s2     = s.s1;
      next_s.s3     = s.s2;
      next_s.stable = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.stable);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '{s1: INIT, s2: INIT, s3: INIT, stable: INIT};
      end else begin
         s <= next_s;
      end
   end

   assign pins.stable = s.stable;

endmodule

`default_nettype wire

/* File: design/board_watchdog_reset_control.sv */
/*
 Board watchdog and reset control: enable/identity register, write-only
 watchdog clear register and expansion site reset register, reached over
 the processor's asynchronous I/O strobes with a 4-bit data path.
 Assumes the strobes, address and data are asynchronous to clk, that an
 outside decoder marks the clock chip area, and that reset is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

`include "watchdog_consts.svh"

module board_watchdog_reset_control
   import watchdog_pkg::*;
#(
   parameter bit EXTENDED       = 1'b1,
   parameter int LATENCY_CYCLES = `WDT_LATENCY_CYCLES,
   parameter int RESET_CYCLES   = `BOARD_RESET_CYCLES
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Processor I/O strobes
   input  wire logic       io_cs_n,
   input  wire logic       io_we_n,
   input  wire logic       io_re_n,
   input  wire logic [1:0] io_addr,
   input  wire logic [3:0] io_data_in,
   output logic      [3:0] io_data_out,
   output logic            io_data_oe_n,
   // Clock chip
   input  wire logic       clock_chip_area_n,
   output logic            clock_chip_cs_n,
   input  wire logic       clock_chip_wdt_n,
   // Board reset and watchdog
   output logic            board_reset,
   output logic            wdt_expire,
   // Expansion site resets
   output logic      [2:0] site_reset_n
);

   localparam wdt_count_t WDT_LAST = wdt_count_t'(LATENCY_CYCLES - 1);
   localparam logic [7:0] RST_LAST = 8'(RESET_CYCLES - 1);
   localparam logic [9:0] PIN_INIT = 10'h3ff;

   localparam core_state_s RESET_STATE = '{
      enables:   `RESET_ENABLES,
      sites:     `RESET_SITES,
      count:     '0,
      expire:    1'b0,
      bstate:    BOARD_RUN,
      rcount:    8'h00,
      prev_cs_n: 1'b1,
      prev_we_n: 1'b1,
      prev_addr: 2'h0,
      prev_data: 4'h0,
      rdata:     4'h0,
      rdrive:    1'b0
   };

   generate
      if (LATENCY_CYCLES < 2 || LATENCY_CYCLES > 33554432) begin : g_lat_chk
         $error("LATENCY_CYCLES out of range for the watchdog counter");
      end
      if (RESET_CYCLES < 1 || RESET_CYCLES > 256) begin : g_rst_chk
         $error("RESET_CYCLES out of range for the reset stretcher");
      end
   endgenerate

   core_state_s s;
   core_state_s next_s;

   // Settled pin levels
   pin_sync_if #(.W(10)) pins ();

   logic       cs_n;
   logic       we_n;
   logic       re_n;
   logic [1:0] addr;
   nibble_t    data;
   logic       cc_expired;
   logic       write_done;
   logic       clear_hit;

   assign pins.raw = {clock_chip_wdt_n, io_data_in, io_addr, io_re_n, io_we_n, io_cs_n};

   pin_sync3 #(.W(10), .INIT(PIN_INIT)) u_pin_sync (
      .clk   (clk),
      .reset (reset),
      .pins  (pins.sync)
   );

   assign cs_n       = pins.stable[0];
   assign we_n       = pins.stable[1];
   assign re_n       = pins.stable[2];
   assign addr       = pins.stable[4:3];
   assign data       = pins.stable[8:5];
   assign cc_expired = ~pins.stable[9];

   // Write completes on the trailing edge of the write strobe
   assign write_done = ~s.prev_cs_n & ~s.prev_we_n & we_n;
   assign clear_hit  = write_done && (s.prev_addr == `REG_WDT_CLEAR);

   // Read value of a register index
   function automatic nibble_t read_value(input logic [1:0] a, input core_state_s st);
      nibble_t v;
      v = 4'h0;
      unique case (a)
         `REG_ENABLE_ID: begin
            v = st.enables;
            v[`BIT_VARIANT] = EXTENDED;
         end
         `REG_SITE_RESET: begin
            v = {1'b0, st.sites};
         end
         default: begin
            v = 4'h0;
         end
      endcase
      return v;
   endfunction

   always_comb begin
      next_s           = s;
      next_s.prev_cs_n = cs_n;
      next_s.prev_we_n = we_n;
      next_s.prev_addr = addr;
      next_s.prev_data = data;

      // latency counter
      // A clear that lands on the last count still counts as a restart
      next_s.expire = (s.count == WDT_LAST) && !clear_hit;
      if (clear_hit || s.count == WDT_LAST) begin
         next_s.count = '0;
      end else begin
         next_s.count = s.count + 1'b1;
      end

      if (write_done && s.prev_addr == `REG_ENABLE_ID) begin
         next_s.enables[`BIT_WATCHDOG_RESET_ENABLE]    = s.prev_data[`BIT_WATCHDOG_RESET_ENABLE];
         next_s.enables[`BIT_VARIANT]   = 1'b0;
         next_s.enables[`BIT_ACCESS_EN] = EXTENDED & s.prev_data[`BIT_ACCESS_EN];
         next_s.enables[`BIT_CC_WATCHDOG_RESET_ENABLE] = EXTENDED & s.prev_data[`BIT_CC_WATCHDOG_RESET_ENABLE];
      end
      if (write_done && s.prev_addr == `REG_SITE_RESET) begin
         next_s.sites[`BIT_PAR_SITE]  = s.prev_data[`BIT_PAR_SITE];
         next_s.sites[`BIT_SER_SITES] = s.prev_data[`BIT_SER_SITES];
         next_s.sites[`BIT_MINI_EXT]  = EXTENDED & s.prev_data[`BIT_MINI_EXT];
      end

      next_s.rdrive = ~cs_n & ~re_n;
      next_s.rdata  = read_value(addr, s);

      unique case (s.bstate)
         BOARD_RUN: begin
            if ((s.expire && s.enables[`BIT_WATCHDOG_RESET_ENABLE]) ||
                (cc_expired && s.enables[`BIT_CC_WATCHDOG_RESET_ENABLE])) begin
               next_s.bstate = BOARD_RESETTING;
               next_s.rcount = 8'h00;
            end
         end
         BOARD_RESETTING: begin
            next_s.enables = `RESET_ENABLES;
            next_s.sites   = `RESET_SITES;
            next_s.count   = '0;
            next_s.rdrive  = 1'b0;
            next_s.rcount  = s.rcount + 8'h01;
            if (s.rcount == RST_LAST) begin
               next_s.bstate = BOARD_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   assign io_data_out  = s.rdata;
   assign io_data_oe_n = ~s.rdrive;
   assign board_reset  = (s.bstate == BOARD_RESETTING);
   assign wdt_expire   = s.expire;
   // zero holds the site in reset
   assign site_reset_n = s.sites;
   assign clock_chip_cs_n = clock_chip_area_n | ~s.enables[`BIT_ACCESS_EN];

   // Helper: watchdog count reached its last cycle
   logic wdt_hit;
   assign wdt_hit = (s.count == WDT_LAST);

   expire_pulse_a: assert property (
      @(posedge clk) disable iff (reset)
      (wdt_hit && !clear_hit) |=> wdt_expire ##1 !wdt_expire
   ) else $error("watchdog expiry pulse missing or too long");

   clear_restart_a: assert property (
      @(posedge clk) disable iff (reset)
      clear_hit |=> (s.count == '0) && !wdt_expire
   ) else $error("clear write did not restart the watchdog");

   wdt_ignored_a: assert property (
      @(posedge clk) disable iff (reset)
      (!board_reset && wdt_expire && !s.enables[`BIT_WATCHDOG_RESET_ENABLE] &&
       !(cc_expired && s.enables[`BIT_CC_WATCHDOG_RESET_ENABLE])) |=> !board_reset
   ) else $error("board reset from a disabled watchdog");

   wdt_resets_a: assert property (
      @(posedge clk) disable iff (reset)
      (!board_reset && wdt_expire && s.enables[`BIT_WATCHDOG_RESET_ENABLE]) |=> board_reset [*2]
   ) else $error("enabled watchdog expiry gave no board reset");

   cc_ignored_a: assert property (
      @(posedge clk) disable iff (reset)
      (!board_reset && cc_expired && !s.enables[`BIT_CC_WATCHDOG_RESET_ENABLE] &&
       !(wdt_expire && s.enables[`BIT_WATCHDOG_RESET_ENABLE])) |=> !board_reset
   ) else $error("board reset from a disabled clock chip watchdog");

   cc_resets_a: assert property (
      @(posedge clk) disable iff (reset)
      (!board_reset && cc_expired && s.enables[`BIT_CC_WATCHDOG_RESET_ENABLE]) |=> board_reset
   ) else $error("clock chip expiry gave no board reset");

   access_block_a: assert property (
      @(posedge clk) disable iff (reset)
      !s.enables[`BIT_ACCESS_EN] |-> clock_chip_cs_n
   ) else $error("clock chip selected while access disabled");

   variant_read_a: assert property (
      @(posedge clk) disable iff (reset)
      (!board_reset && !cs_n && !re_n && addr == `REG_ENABLE_ID) |=>
         !io_data_oe_n && (io_data_out[`BIT_VARIANT] == EXTENDED)
   ) else $error("variant bit reads wrong");

   site_write_a: assert property (
      @(posedge clk) disable iff (reset)
      (!board_reset && write_done && s.prev_addr == `REG_SITE_RESET) |=>
         site_reset_n[1:0] == $past(s.prev_data[1:0])
   ) else $error("site reset lines do not follow the written field");

   board_defaults_a: assert property (
      @(posedge clk) disable iff (reset)
      $rose(board_reset) |=> (s.enables == 4'h0) && (site_reset_n == 3'h0)
   ) else $error("board reset left fields at non-default values");

   count_range_a: assert property (
      @(posedge clk) disable iff (reset)
      s.count <= WDT_LAST
   ) else $error("watchdog count ran past its last value");

   expire_source_a: assert property (
      @(posedge clk) disable iff (reset)
      wdt_expire |-> $past(wdt_hit) && !$past(clear_hit)
   ) else $error("expiry pulse without an unrestarted latency period");

   stretch_hold_a: assert property (
      @(posedge clk) disable iff (reset)
      (board_reset && s.rcount != RST_LAST) |=> board_reset
   ) else $error("board reset ended before its full width");

   stretch_end_a: assert property (
      @(posedge clk) disable iff (reset)
      (board_reset && s.rcount == RST_LAST) |=> !board_reset
   ) else $error("board reset stretched past its width");

   read_refused_a: assert property (
      @(posedge clk) disable iff (reset)
      board_reset |=> io_data_oe_n
   ) else $error("data driven during board reset");

   access_pass_a: assert property (
      @(posedge clk) disable iff (reset)
      (s.enables[`BIT_ACCESS_EN] && !clock_chip_area_n) |-> !clock_chip_cs_n
   ) else $error("clock chip not selected while access enabled");

   enable_write_a: assert property (
      @(posedge clk) disable iff (reset)
      (!board_reset && write_done && s.prev_addr == `REG_ENABLE_ID) |=>
         (s.enables[`BIT_WATCHDOG_RESET_ENABLE] == $past(s.prev_data[`BIT_WATCHDOG_RESET_ENABLE])) &&
         (s.enables[`BIT_CC_WATCHDOG_RESET_ENABLE] == (EXTENDED & $past(s.prev_data[`BIT_CC_WATCHDOG_RESET_ENABLE])))
   ) else $error("enable bits do not follow the written value");

endmodule

`default_nettype wire

/* File: verification/proc_bus_model.sv */
/*
 Processor side of the asynchronous I/O strobes: one task makes a whole
 read or write cycle. Assumes the block settles strobes within 6 clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module proc_bus_model (
   // Clock
   input  wire logic       clk,
   // Strobes to the block
   output logic            io_cs_n,
   output logic            io_we_n,
   output logic            io_re_n,
   output logic      [1:0] io_addr,
   output logic      [3:0] io_data_in,
   // Answer from the block
   input  wire logic [3:0] io_data_out,
   input  wire logic       io_data_oe_n
);
   initial begin
      io_cs_n    = 1'b1;
      io_we_n    = 1'b1;
      io_re_n    = 1'b1;
      io_addr    = 2'h3;
      io_data_in = 4'h0;
   end

   // strobes held low then high for 8 clocks
   task automatic access(input logic wr, input logic [1:0] a, input logic [3:0] d,
                         output logic [3:0] q, output logic oe_n);
      @(posedge clk);
      io_cs_n    <= 1'b0;
      io_we_n    <= ~wr;
      io_re_n    <= wr;
      io_addr    <= a;
      io_data_in <= d;
      repeat (8) @(posedge clk);
      q = io_data_out;
      oe_n = io_data_oe_n;
      io_cs_n    <= 1'b1;
      io_we_n    <= 1'b1;
      io_re_n    <= 1'b1;
      // Released lines no longer show the old value
      io_addr    <= ~a;
      io_data_in <= ~d;
      repeat (8) @(posedge clk);
   endtask
endmodule

`default_nettype wire

/* File: verification/board_watchdog_reset_control_tb.sv */
/*
 Self-checking bench of the board watchdog and reset control block.
 Assumes short latency and board reset counts set by parameter.
*/
`timescale 1ns/1ps
`default_nettype none

module board_watchdog_reset_control_tb;
   import watchdog_pkg::*;

   logic       clk;
   logic       reset;
   logic       io_cs_n;
   logic       io_we_n;
   logic       io_re_n;
   logic [1:0] io_addr;
   logic [3:0] io_data_in;
   logic [3:0] io_data_out;
   logic       io_data_oe_n;
   logic       clock_chip_area_n;
   logic       clock_chip_cs_n;
   logic       clock_chip_wdt_n;
   logic       board_reset;
   logic       wdt_expire;
   logic [2:0] site_reset_n;
   int         n_mismatch;
   int         comparisons;
   int         n_brst;
   int         n_exp;

   board_watchdog_reset_control #(.EXTENDED(1'b1), .LATENCY_CYCLES(200), .RESET_CYCLES(4))
   i_board_watchdog_reset_control (
      .clk(clk), .reset(reset), .io_cs_n(io_cs_n), .io_we_n(io_we_n),
      .io_re_n(io_re_n), .io_addr(io_addr), .io_data_in(io_data_in),
      .io_data_out(io_data_out), .io_data_oe_n(io_data_oe_n),
      .clock_chip_area_n(clock_chip_area_n), .clock_chip_cs_n(clock_chip_cs_n),
      .clock_chip_wdt_n(clock_chip_wdt_n), .board_reset(board_reset),
      .wdt_expire(wdt_expire), .site_reset_n(site_reset_n));

   proc_bus_model i_proc_bus_model (
      .clk(clk), .io_cs_n(io_cs_n), .io_we_n(io_we_n), .io_re_n(io_re_n),
      .io_addr(io_addr), .io_data_in(io_data_in), .io_data_out(io_data_out),
      .io_data_oe_n(io_data_oe_n));

   initial clk = 1'b0;
   always #25 clk = ~clk;

   // Counts of board reset cycles and expiry pulses
   always @(posedge clk) begin
      n_brst <= n_brst + int'(board_reset === 1'b1);
      n_exp  <= n_exp + int'(wdt_expire === 1'b1);
   end

   task automatic check(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [3:0] d);
      logic [3:0] q;
      logic       oe;
      i_proc_bus_model.access(1'b1, a, d, q, oe);
   endtask

   task automatic rd(input logic [1:0] a, input logic [3:0] exp);
      logic [3:0] q;
      logic       oe;
      i_proc_bus_model.access(1'b0, a, 4'h0, q, oe);
      check({3'h0, oe}, 4'h0);
      check(q, exp);
      check({3'h0, io_data_oe_n}, 4'h1);
   endtask

   task automatic t_reset();
      rd(2'h0, 4'h2);
      rd(2'h2, 4'h0);
      check({1'b0, site_reset_n}, 4'h0);
      rd(2'h1, 4'h0);
      rd(2'h3, 4'h0);
      $display("test reset done");
   endtask

   task automatic t_sites();
      wr(2'h2, 4'h7);
      check({1'b0, site_reset_n}, 4'h7);
      rd(2'h2, 4'h7);
      wr(2'h2, 4'ha);
      check({1'b0, site_reset_n}, 4'h2);
      rd(2'h2, 4'h2);
      $display("test sites done");
   endtask

   task automatic t_access();
      clock_chip_area_n <= 1'b0;
      @(posedge clk);
      #1 check({3'h0, clock_chip_cs_n}, 4'h1);
      wr(2'h0, 4'h4);
      #1 check({3'h0, clock_chip_cs_n}, 4'h0);
      rd(2'h0, 4'h6);
      clock_chip_area_n <= 1'b1;
      @(posedge clk);
      #1 check({3'h0, clock_chip_cs_n}, 4'h1);
      $display("test access done");
   endtask

   task automatic t_expire_off();
      int e0;
      int b0;
      e0 = n_exp;
      b0 = n_brst;
      for (int i = 0; i < 300 && n_exp == e0; i++) @(posedge clk);
      check({3'h0, n_exp != e0}, 4'h1);
      repeat (4) @(posedge clk);
      check({3'h0, n_brst == b0}, 4'h1);
      $display("test expire off done");
   endtask

   task automatic t_restart_bite();
      int e0;
      int b0;
      wr(2'h1, 4'h0);
      wr(2'h2, 4'h7);
      wr(2'h0, 4'h5);
      e0 = n_exp;
      b0 = n_brst;
      for (int i = 0; i < 15; i++) wr(2'h1, 4'(i));
      check({3'h0, n_exp == e0}, 4'h1);
      check({3'h0, n_brst == b0}, 4'h1);
      repeat (260) @(posedge clk);
      check(4'(n_brst - b0), 4'h4);
      check({1'b0, site_reset_n}, 4'h0);
      rd(2'h0, 4'h2);
      $display("test restart and bite done");
   endtask

   task automatic t_clock_chip();
      int b0;
      b0 = n_brst;
      clock_chip_wdt_n <= 1'b0;
      repeat (20) @(posedge clk);
      check({3'h0, n_brst == b0}, 4'h1);
      wr(2'h0, 4'h8);
      repeat (20) @(posedge clk);
      check(4'(n_brst - b0), 4'h4);
      clock_chip_wdt_n <= 1'b1;
      rd(2'h0, 4'h2);
      $display("test clock chip done");
   endtask

   task automatic summarize();
      $display("counts: comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #(20000 * 50);
      n_mismatch++;
      summarize();
   end

   initial begin
      n_mismatch = 0;
      comparisons = 0;
      n_brst = 0;
      n_exp = 0;
      reset = 1'b1;
      clock_chip_area_n = 1'b1;
      clock_chip_wdt_n = 1'b1;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_sites();
      t_access();
      t_expire_off();
      t_restart_bite();
      t_clock_chip();
      summarize();
   end
endmodule

`default_nettype wire
